// ---- cwp_pkg.sv ----
// constants, types and helpers for the option word loader and access guard
// assumes a 40 MHz pclk and word-indexed configuration locations
//
// Contract
// - option words sit at indexes 8007h and 8008h
// - word one bits 13,12 enable monitor, switchover
// - word one bit 11 low drives clock output
// - brown-out field: always, run-only, software, off
// - bit 5 low enables power-up timer only
// - watchdog field: always, run-only, software, off
// - reset pin select ignored under low-voltage programming
// - program protect blocks external access, reads zero
// - data protect blocks external eeprom reads, writes
// - clearing protection erases the protected memory whole
// - three-bit field picks the oscillator mode
// - low-voltage entry bit; not clearable in that mode
// - debug bit low dedicates programming pins
// - brown-out level bit: 1.9V set, 2.5V clear
// - stack fault reset follows word two bit 9
// - multiplier enable follows its option bit
// - regulator cap pin field; low-voltage variant reads 11
// - unimplemented option bits read as one
// - small part self-write protect ranges blocked
// - large part self-write protect ranges blocked
// - four user id words, readable and writable
// - part and revision word ignores all writes
package cwp_pkg;
  // ------------------------------------------------------------------
  // location indexes, byte address is four times the index
  // ------------------------------------------------------------------
  localparam logic [15:0] IDX_UID0  = 16'h8000;
  localparam logic [15:0] IDX_UID3  = 16'h8003;
  localparam logic [15:0] IDX_DEVID = 16'h8006;
  localparam logic [15:0] IDX_WORD1 = 16'h8007;
  localparam logic [15:0] IDX_WORD2 = 16'h8008;
  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int B_FCM = 13, B_TWO_SPEED_SWITCHOVER_ENABLE = 12, B_CLKO = 11, B_BOR = 9;
  localparam int B_CPD = 8, B_CP = 7, B_RSEL = 6, B_POWERUP_TIMER = 5;
  localparam int B_WDT = 3, B_OSC = 0;
  localparam int B_LVP = 13, B_DBG = 12, B_BROWNOUT_LEVEL_SELECT = 10, B_STK = 9;
  localparam int B_PLL = 8, B_REGULATOR_CAPACITOR = 4, B_WRT = 0;
  // ------------------------------------------------------------------
  // reset and blank values
  // ------------------------------------------------------------------
  localparam logic [13:0] W_BLANK     = 14'h3FFF;
  localparam logic [13:0] W2_UNIMPL   = 14'h08CC;
  localparam logic [1:0]  REGULATOR_CAPACITOR_NONE   = 2'h3;
  localparam logic [1:0]  WRT_OFF     = 2'h3;
  // self-write protect upper limits
  localparam logic [12:0] LIM_200     = 13'h01FF;
  localparam logic [12:0] LIM_800     = 13'h07FF;
  localparam logic [12:0] LIM_1000    = 13'h0FFF;
  localparam logic [12:0] LIM_2000    = 13'h1FFF;
  // oscillator codes
  localparam logic [2:0]  OSC_INT     = 3'h4;
  localparam logic [2:0]  OSC_RC      = 3'h3;

  // loader states, one-hot
  typedef enum logic [1:0] {ST_LOAD = 2'b01, ST_RUN = 2'b10} cwp_state_t;

  // byte address of a word index
  function automatic logic [17:0] cwp_badr(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction

  // {active while running, active in sleep} of a four-way enable field
  function automatic logic [1:0] cwp_mode(input logic [1:0] f, input logic sw);
    logic run;
    logic slp;
    run = (f == 2'h3) || (f == 2'h2) || ((f == 2'h1) && sw);
    slp = (f == 2'h3) || ((f == 2'h1) && sw);
    return {run, slp};
  endfunction
endpackage

// ---- cwp_prot_if.sv ----
// protection settings handed from the loader to the access guard
// assumes both ends sit in the pclk domain
`timescale 1ns/1ps
interface cwp_prot_if;
  logic       prog_protect_n;  // program memory guard, low active
  logic       data_protect_n;  // eeprom guard, low active
  logic [1:0] wr_field;        // self-write protect code
  modport src  (output prog_protect_n, data_protect_n, wr_field);
  modport gate (input  prog_protect_n, data_protect_n, wr_field);
endinterface

// ---- cwp_access_gate.sv ----
// guard for external and self-initiated memory accesses
// assumes settings are stable after load and requests synchronous to pclk
`timescale 1ns/1ps
module cwp_access_gate
  import cwp_pkg::*;
#(
  parameter bit LARGE_PART = 1'b1  // 8K-word layout when set
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // settings
  cwp_prot_if.gate         prot,
  // external programmer request
  input  wire logic        ext_mem,
  input  wire logic        ext_write,
  input  wire logic        ext_is_data,
  output wire logic        mem_rd_en,
  output wire logic        mem_wr_en,
  output wire logic        ext_blocked,
  // cpu self-write
  input  wire logic        self_wr_req,
  input  wire logic [12:0] self_wr_addr,
  output wire logic        self_wr_grant
);
  // ------------------------------------------------------------------
  // range decode
  // ------------------------------------------------------------------
  // top protected address for a field code
  function automatic logic [12:0] lim(input logic [1:0] f);
    case (f)
      2'h2:    return LIM_200;
      2'h1:    return LARGE_PART ? LIM_1000 : LIM_800;
      default: return LARGE_PART ? LIM_2000 : LIM_1000;
    endcase
  endfunction

  wire logic guarded;   // external access hits an enabled guard
  wire logic self_hit;  // self-write falls in protected range

  assign guarded  = ext_is_data ? !prot.data_protect_n
                                : !prot.prog_protect_n;
  assign self_hit = (prot.wr_field != WRT_OFF)
                  && (self_wr_addr <= lim(prot.wr_field));
  // cpu fetches never pass here, so the guards cannot stall execution
  assign mem_rd_en     = ext_mem && !ext_write && !guarded;
  assign mem_wr_en     = ext_mem && ext_write && !guarded;
  assign ext_blocked   = ext_mem && guarded;
  assign self_wr_grant = self_wr_req && !self_hit;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_ext_data_block: assert property (@(posedge pclk) disable iff (!presetn)
    ext_mem && ext_is_data && !prot.data_protect_n |-> !mem_rd_en && !mem_wr_en)
    else $error("eeprom reached while guarded");
  a_self_wr_range: assert property (@(posedge pclk) disable iff (!presetn)
    self_wr_req && prot.wr_field == 2'h2 && self_wr_addr <= LIM_200
      |-> !self_wr_grant)
    else $error("boot block self-write granted");
endmodule

// ---- cwp_config_loader.sv ----
// option word loader with user id store and access guarding
// assumes nv words are valid while reset is released, apb master on pclk
`timescale 1ns/1ps
module cwp_config_loader
  import cwp_pkg::*;
#(
  parameter bit         LARGE_PART  = 1'b1,   // 8K-word layout
  parameter bit         LOW_VOLT    = 1'b0,   // low-voltage variant
  parameter logic [8:0] PART_CODE   = 9'h0A5, // arbitrary value
  parameter logic [4:0] REV_CODE    = 5'h03   // arbitrary value
) (
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output wire logic [31:0] prdata,
  output wire logic        pready,
  output wire logic        pslverr,
  // non-volatile store
  input  wire logic [13:0] nv_word_one,
  input  wire logic [13:0] nv_word_two,
  output logic             nv_wr_en,
  output logic [15:0]      nv_wr_index,
  output logic [13:0]      nv_wr_data,
  output logic             erase_program_all,
  output logic             erase_data_all,
  // external programmer
  input  wire logic        lvp_entered,
  input  wire logic        ext_valid,
  input  wire logic        ext_write,
  input  wire logic        ext_is_data,
  input  wire logic [15:0] ext_addr,
  input  wire logic [13:0] ext_wdata,
  output logic [13:0]      ext_rdata,
  output logic             ext_rdata_valid,
  output wire logic        ext_blocked,
  // memory array
  input  wire logic [13:0] mem_rdata,
  output wire logic        mem_rd_en,
  output wire logic        mem_wr_en,
  // cpu self-write
  input  wire logic        self_wr_req,
  input  wire logic [12:0] self_wr_addr,
  output wire logic        self_wr_grant,
  // software enables
  input  wire logic        software_brownout_enable,
  input  wire logic        software_watchdog_enable,
  input  wire logic        reset_pin_pullup_enable,
  // decoded options
  output wire logic        failsafe_monitor_enable,
  output wire logic        two_speed_switchover_enable,
  output wire logic        clock_output_active,
  output wire logic        brownout_active_run,
  output wire logic        brownout_active_sleep,
  output wire logic        powerup_timer_active,
  output wire logic        watchdog_active_run,
  output wire logic        watchdog_active_sleep,
  output wire logic        reset_pin_is_reset,
  output wire logic        reset_pin_pullup,
  output wire logic [2:0]  oscillator_select_field,
  output wire logic        osc_internal,
  output wire logic        osc_external_clock,
  output wire logic        osc_crystal,
  output wire logic        low_voltage_program_enable,
  output wire logic        debug_pins_dedicated,
  output wire logic        brownout_trip_low,
  output wire logic        stack_fault_reset_enable,
  output wire logic        multiplier_enable,
  output wire logic [2:0]  regulator_cap_pin,
  output wire logic        options_valid
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  cwp_state_t  state_ff;          // loader phase
  logic [13:0] word1_ff;          // option word one as loaded
  logic [13:0] word2_ff;          // option word two as loaded
  logic [13:0] uid_ff [4];        // user id words
  logic [13:0] nxt_word2;         // word two with fixed bits applied
  cwp_prot_if  prot ();           // guard settings

  // ------------------------------------------------------------------
  // option load
  // ------------------------------------------------------------------
  // unimplemented bits forced to one, cap field fixed on low-volt parts
  assign nxt_word2 = (nv_word_two | W2_UNIMPL)
                   | (LOW_VOLT ? {8'h00, REGULATOR_CAPACITOR_NONE, 4'h0} : 14'h0000);

  // words are sampled by the clock after release, never by the reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_LOAD;
      word1_ff <= W_BLANK;
      word2_ff <= W_BLANK;
    end else if (ce) begin
      case (state_ff)
        ST_LOAD: begin
          word1_ff <= nv_word_one;
          word2_ff <= nxt_word2;
          state_ff <= ST_RUN;
        end
        ST_RUN:  state_ff <= ST_RUN; // held until the next reset
        default: state_ff <= ST_LOAD;
      endcase
    end
  end
  assign options_valid = (state_ff == ST_RUN);

  // ------------------------------------------------------------------
  // option decode
  // ------------------------------------------------------------------
  wire logic [1:0] bor_m;  // brown-out {run, sleep}
  wire logic [1:0] wdt_m;  // watchdog {run, sleep}
  assign bor_m = cwp_mode(word1_ff[B_BOR+:2], software_brownout_enable);
  assign wdt_m = cwp_mode(word1_ff[B_WDT+:2], software_watchdog_enable);

  assign failsafe_monitor_enable     = word1_ff[B_FCM];
  assign two_speed_switchover_enable = word1_ff[B_TWO_SPEED_SWITCHOVER_ENABLE];
  assign clock_output_active         = !word1_ff[B_CLKO];
  assign brownout_active_run         = bor_m[1];
  assign brownout_active_sleep       = bor_m[0];
  // brown-out never implies the power-up timer
  assign powerup_timer_active        = !word1_ff[B_POWERUP_TIMER];
  assign watchdog_active_run         = wdt_m[1];
  assign watchdog_active_sleep       = wdt_m[0];
  // with low-voltage entry the select bit is ignored and reset stays
  assign reset_pin_is_reset = word2_ff[B_LVP] || word1_ff[B_RSEL];
  assign reset_pin_pullup   = reset_pin_is_reset || reset_pin_pullup_enable;
  assign oscillator_select_field     = word1_ff[B_OSC+:3];
  assign osc_external_clock          = word1_ff[B_OSC+2] && (word1_ff[B_OSC+:3] != OSC_INT);
  assign osc_internal                = (word1_ff[B_OSC+:3] == OSC_INT);
  assign osc_crystal                 = !word1_ff[B_OSC+2] && (word1_ff[B_OSC+:3] != OSC_RC);
  assign low_voltage_program_enable  = word2_ff[B_LVP];
  assign debug_pins_dedicated        = !word2_ff[B_DBG];
  assign brownout_trip_low           = word2_ff[B_BROWNOUT_LEVEL_SELECT];
  assign stack_fault_reset_enable    = word2_ff[B_STK];
  assign multiplier_enable           = word2_ff[B_PLL];
  // one-hot cap pin, all clear when no capacitor
  assign regulator_cap_pin = (word2_ff[B_REGULATOR_CAPACITOR+:2] == REGULATOR_CAPACITOR_NONE) ? 3'h0
                           : 3'(3'h1 << word2_ff[B_REGULATOR_CAPACITOR+:2]);

  // ------------------------------------------------------------------
  // protection guard
  // ------------------------------------------------------------------
  assign prot.prog_protect_n = word1_ff[B_CP];
  assign prot.data_protect_n = word1_ff[B_CPD];
  assign prot.wr_field       = word2_ff[B_WRT+:2];

  wire logic ext_go;    // programmer request taken this edge
  wire logic ext_cfg;   // request aims at the configuration space
  assign ext_go  = ce && ext_valid;
  assign ext_cfg = ext_addr[15];

  cwp_access_gate #(.LARGE_PART(LARGE_PART)) u_gate (
    .pclk          (pclk),
    .presetn       (presetn),
    .prot          (prot.gate),
    .ext_mem       (ext_go && !ext_cfg),
    .ext_write     (ext_write),
    .ext_is_data   (ext_is_data),
    .mem_rd_en     (mem_rd_en),
    .mem_wr_en     (mem_wr_en),
    .ext_blocked   (ext_blocked),
    .self_wr_req   (self_wr_req && ce),
    .self_wr_addr  (self_wr_addr),
    .self_wr_grant (self_wr_grant)
  );

  // ------------------------------------------------------------------
  // location decode
  // ------------------------------------------------------------------
  wire logic [13:0] devid_word;  // part and revision
  wire logic        e_uid;       // external hit on user id
  wire logic        e_w1;        // external hit on word one
  wire logic        e_w2;        // external hit on word two
  wire logic        e_dev;       // external hit on part code
  assign devid_word = {PART_CODE, REV_CODE};
  assign e_uid = ext_addr[15:2] == IDX_UID0[15:2];
  assign e_w1  = ext_addr == IDX_WORD1;
  assign e_w2  = ext_addr == IDX_WORD2;
  assign e_dev = ext_addr == IDX_DEVID;

  // configuration space read data for the programmer
  wire logic [13:0] cfg_rd;
  assign cfg_rd = e_uid ? uid_ff[ext_addr[1:0]]
                : e_dev ? devid_word
                : e_w1  ? word1_ff
                : e_w2  ? word2_ff : 14'h0000;

  // word two image, low-voltage entry bit cannot be cleared in that mode
  wire logic [13:0] ext_w2;
  assign ext_w2 = lvp_entered ? (ext_wdata | 14'(1 << B_LVP)) : ext_wdata;

  // ------------------------------------------------------------------
  // programmer side
  // ------------------------------------------------------------------
  // read data one cycle after the request; a guarded read returns zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_rdata       <= 14'h0000;
      ext_rdata_valid <= 1'b0;
    end else if (ce) begin
      ext_rdata_valid <= ext_valid && !ext_write;
      if (ext_valid && !ext_write) begin
        ext_rdata <= ext_cfg ? cfg_rd : mem_rd_en ? mem_rdata : 14'h0000;
      end
    end
  end

  // option writes go to the store and only act after the next reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_wr_en          <= 1'b0;
      nv_wr_index       <= 16'h0000;
      nv_wr_data        <= 14'h0000;
      erase_program_all <= 1'b0;
      erase_data_all    <= 1'b0;
    end else if (ce) begin
      nv_wr_en          <= ext_valid && ext_write && ext_cfg && (e_w1 || e_w2);
      erase_program_all <= 1'b0;
      erase_data_all    <= 1'b0;
      if (ext_valid && ext_write && e_w1) begin
        nv_wr_index       <= IDX_WORD1;
        nv_wr_data        <= ext_wdata;
        // lifting a guard wipes what it guarded, pulsed on the same edge as the option write
        erase_program_all <= !word1_ff[B_CP] && ext_wdata[B_CP];
        erase_data_all    <= !word1_ff[B_CPD] && ext_wdata[B_CPD];
      end else if (ext_valid && ext_write && e_w2) begin
        nv_wr_index <= IDX_WORD2;
        nv_wr_data  <= ext_w2;
      end
    end
  end

  // ------------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------------
  wire logic       a_uid;   // apb hit on user id words
  wire logic       a_ro;    // apb hit on read-only words
  wire logic       a_hit;   // any mapped word
  wire logic       a_wr;    // write completes this edge
  wire logic [1:0] a_sel;   // user id select
  // byte address bits 17:4 are index bits 15:2 of the first user id word
  assign a_uid = (paddr[17:4] == IDX_UID0[15:2]) && (paddr[1:0] == 2'h0);
  assign a_ro  = (paddr == cwp_badr(IDX_DEVID)) || (paddr == cwp_badr(IDX_WORD1))
              || (paddr == cwp_badr(IDX_WORD2));
  assign a_hit = a_uid || a_ro;
  assign a_sel = paddr[3:2];
  assign a_wr  = ce && psel && penable && pwrite && a_uid;
  // a frozen block stretches the access instead of dropping it
  assign pready  = ce;
  assign pslverr = psel && penable && !a_hit;
  assign prdata  = !(psel && !pwrite) ? 32'h0000_0000
                 : a_uid ? {18'h00000, uid_ff[a_sel]}
                 : (paddr == cwp_badr(IDX_DEVID)) ? {18'h00000, devid_word}
                 : (paddr == cwp_badr(IDX_WORD1)) ? {18'h00000, word1_ff}
                 : (paddr == cwp_badr(IDX_WORD2)) ? {18'h00000, word2_ff}
                 : 32'h0000_0000;

  // user id store; the programmer wins a same-edge collision
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) uid_ff[i] <= W_BLANK;
    end else if (ext_go && ext_write && ext_cfg && e_uid) begin
      uid_ff[ext_addr[1:0]] <= ext_wdata;
    end else if (a_wr) begin
      uid_ff[a_sel] <= pwdata[13:0];
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_words_hold: assert property (@(posedge pclk) disable iff (!presetn)
    options_valid |=> options_valid && $stable(word1_ff) && $stable(word2_ff))
    else $error("option words changed after load");
  a_unimpl_one: assert property (@(posedge pclk) disable iff (!presetn)
    options_valid |-> (word2_ff & W2_UNIMPL) == W2_UNIMPL)
    else $error("unimplemented option bit reads zero");
  a_bor_modes: assert property (@(posedge pclk) disable iff (!presetn)
    word1_ff[B_BOR+:2] == 2'h2 |-> brownout_active_run && !brownout_active_sleep)
    else $error("run-only brown-out mode wrong");
  a_wdt_off: assert property (@(posedge pclk) disable iff (!presetn)
    word1_ff[B_WDT+:2] == 2'h0 |-> !watchdog_active_run && !watchdog_active_sleep)
    else $error("watchdog active while disabled");
  a_pin_lvp: assert property (@(posedge pclk) disable iff (!presetn)
    low_voltage_program_enable |-> reset_pin_is_reset && reset_pin_pullup)
    else $error("reset pin select not ignored");
  a_lvp_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    ce && ext_valid && ext_write && e_w2 && lvp_entered
      |=> nv_wr_en && nv_wr_data[B_LVP] && nv_wr_index == IDX_WORD2)
    else $error("low-voltage bit cleared in low-voltage mode");
  a_prog_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    ce && ext_valid && !ext_write && !ext_cfg && !ext_is_data && !word1_ff[B_CP]
      |=> ext_rdata_valid && ext_rdata == 14'h0000)
    else $error("guarded program read leaked data");
  a_erase_lift: assert property (@(posedge pclk) disable iff (!presetn)
    ce && ext_valid && ext_write && e_w1 && !word1_ff[B_CP] && ext_wdata[B_CP]
      |=> erase_program_all ##1 !erase_program_all || $past(ce && ext_valid))
    else $error("lifting program guard did not erase");
  a_devid_ro: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !pwrite && paddr == cwp_badr(IDX_DEVID) |-> prdata[13:0] == devid_word)
    else $error("part code word altered");
endmodule

// ---- cwp_prog_model.sv ----
// programmer model: one-word requests and the memory array reply
// assumes the device takes a request at the rising pclk edge
`timescale 1ns/1ps
module cwp_prog_model (
  // request side
  output logic        ext_valid,
  output logic        ext_write,
  output logic        ext_is_data,
  output logic [15:0] ext_addr,
  output logic [13:0] ext_wdata,
  output logic        lvp_entered,
  // memory array
  input  wire logic   mem_rd_en,
  output logic [13:0] mem_rdata
);
  // idle array shows the inverse word so a stale value never passes
  assign mem_rdata = mem_rd_en ? 14'h1A5C : ~14'h1A5C;
  // entry method and write data are chosen per scenario
  initial lvp_entered = 1'b0;
  initial ext_valid = 1'b0;
  // low-voltage entry forbids clearing the low-voltage bit
  task automatic set_lvp(input logic v);
    lvp_entered <= v;
  endtask
  // raise a request just after an edge; caller drops it after one edge
  task automatic raise(input logic w, input logic ds, input logic [15:0] a,
                       input logic [13:0] d);
    ext_wdata   <= d;
    ext_valid   <= 1'b1;
    ext_write   <= w;
    ext_is_data <= ds;
    ext_addr    <= a;
  endtask
  task automatic drop();
    ext_valid <= 1'b0;
  endtask
endmodule

// ---- test_cwp_config_loader.sv ----
// self-checking bench: option decode rows, apb registers, programmer guard
// assumes default part parameters and ce held high
`timescale 1ns/1ps
module test_cwp_config_loader;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [13:0] nv_word_one = 14'h3FFF, nv_word_two = 14'h3FFF;
  logic [13:0] nv_wr_data, ext_wdata, ext_rdata, mem_rdata;
  logic [15:0] nv_wr_index, ext_addr;
  logic [12:0] self_wr_addr = '0;
  logic [2:0] oscillator_select_field, regulator_cap_pin;
  logic pready, pslverr, er, nv_wr_en, erase_program_all, erase_data_all, lvp_entered;
  logic ext_valid, ext_write, ext_is_data, ext_rdata_valid, ext_blocked, mem_rd_en;
  logic mem_wr_en, self_wr_req = 1, self_wr_grant, software_brownout_enable = 0;
  logic software_watchdog_enable = 0, reset_pin_pullup_enable = 0, failsafe_monitor_enable;
  logic two_speed_switchover_enable, clock_output_active, brownout_active_run;
  logic brownout_active_sleep, powerup_timer_active, watchdog_active_run;
  logic watchdog_active_sleep, reset_pin_is_reset, reset_pin_pullup, osc_internal;
  logic osc_external_clock, osc_crystal, low_voltage_program_enable, debug_pins_dedicated;
  logic brownout_trip_low, stack_fault_reset_enable, multiplier_enable, options_valid;
  int err_total = 0, n_checks = 0;
  // option words in, decoded vector and self-write grant out
  typedef struct packed {
    logic [13:0] w1, w2; logic sw; logic [12:0] sa; logic [23:0] e; logic g;
  } cwp_row_t;
  cwp_row_t rows [4] = '{'{14'h3FFF, 14'h3FFF, 1'b0, 13'h1FFF, 24'hDBFC17, 1'b1},
    '{14'h2DF4, 14'h3ADD, 1'b0, 13'h0FFF, 24'h9290A7, 1'b0},
    '{14'h13EB, 14'h2DEE, 1'b1, 13'h0200, 24'h7B6F07, 1'b1},
    '{14'h0000, 14'h0000, 1'b0, 13'h1FFF, 24'h240248, 1'b0}};
  cwp_config_loader u_dut (.*);
  cwp_prog_model u_prog (.*);
  always #12.5 pclk = ~pclk;
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // programmer request; guard seen in its cycle, result one edge later
  task prg(input logic w, ds, input logic [15:0] a, input logic [13:0] wd, input logic [2:0] b,
           input logic [13:0] d);
    u_prog.raise(w, ds, a, wd);
    @(negedge pclk);
    chk({ext_blocked, mem_rd_en, mem_wr_en}, b);
    @(posedge pclk);
    u_prog.drop();
    @(negedge pclk);
    if (w) chk({nv_wr_en, erase_program_all, erase_data_all}, d);
    else chk({ext_rdata_valid, ext_rdata}, {1'b1, d});
    @(posedge pclk);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // a hang ends the run as a mismatch
  initial begin
    #40000;
    err_total++;
    end_of_test();
  end
  initial begin
    foreach (rows[i]) begin
      nv_word_one <= rows[i].w1;
      nv_word_two <= rows[i].w2;
      software_brownout_enable <= rows[i].sw;
      software_watchdog_enable <= rows[i].sw;
      self_wr_addr <= rows[i].sa;
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk({failsafe_monitor_enable, two_speed_switchover_enable, clock_output_active,
           brownout_active_run, brownout_active_sleep, powerup_timer_active,
           watchdog_active_run, watchdog_active_sleep, oscillator_select_field,
           stack_fault_reset_enable, multiplier_enable, brownout_trip_low,
           debug_pins_dedicated, regulator_cap_pin, osc_internal, osc_external_clock,
           osc_crystal, reset_pin_is_reset, reset_pin_pullup,
           low_voltage_program_enable}, rows[i].e);
      chk(self_wr_grant, rows[i].g);
      chk(options_valid, 1);
      @(posedge pclk);
      $display("option row %0d done", i);
    end
    apb(1, 18'h20000, 32'hFFFF_2123);
    apb(0, 18'h20000, 0);
    chk(rd, 32'h2123);
    apb(1, 18'h20018, 32'h3FFF);
    apb(0, 18'h20018, 0);
    chk(rd, 32'h14A3);
    apb(0, 18'h2001C, 0);
    chk(rd, 32'h0);
    apb(0, 18'h20020, 0);
    chk(rd, 32'h08CC);
    apb(0, 18'h20010, 0);
    chk(er, 1);
    $display("register test done");
    prg(0, 0, 16'h0010, 14'h3FFF, 3'h4, 14'h0);
    prg(1, 0, 16'h0010, 14'h3FFF, 3'h4, 14'h0);
    prg(0, 1, 16'h0004, 14'h3FFF, 3'h4, 14'h0);
    prg(0, 0, 16'h8006, 14'h3FFF, 3'h0, 14'h14A3);
    prg(1, 0, 16'h8007, 14'h3FFF, 3'h0, 14'h0007);
    u_prog.set_lvp(1'b1);
    prg(1, 0, 16'h8008, 14'h1FFF, 3'h0, 14'h0004);
    chk(nv_wr_data, 14'h3FFF);
    chk(nv_wr_index, 16'h8008);
    $display("programmer test done");
    // mid-run reset with guards lifted: memory path opens
    nv_word_one <= 14'h3FFF;
    presetn <= 1'b0;
    @(negedge pclk);
    chk(options_valid, 1'b0);
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    prg(0, 0, 16'h0010, 14'h3FFF, 3'h2, 14'h1A5C);
    $display("reset test done");
    end_of_test();
  end
endmodule
